// ---- prescaled_reload_timer_pkg.sv ----
// constants for the prescaled reload timer: register indices, fields,
// reset values and timing.
// assumes a single 100 MHz system clock and a word-wide core data bus.
package prescaled_reload_timer_pkg;

  // ----------------------------------------------------------------
  // register indices on the core register port
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_RELOAD_VALUE = 4'h0;
  localparam logic [3:0] IDX_PRESCALE_RELOAD = 4'h1;
  localparam logic [3:0] IDX_MAIN_COUNT = 4'h2;
  localparam logic [3:0] IDX_PRESCALE_COUNT = 4'h3;
  localparam logic [3:0] IDX_CONTROL_A = 4'h4;
  localparam logic [3:0] IDX_CONTROL_B = 4'h5;
  localparam logic [3:0] IDX_PORT_TWO_CONTROL = 4'h6;
  localparam logic [3:0] IDX_T2_LOAD = 4'h7;
  localparam logic [3:0] IDX_T2_COUNT = 4'h8;
  localparam logic [3:0] IDX_T2_CONTROL = 4'h9;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PENDING_BIT = 15;
  localparam int PRESCALE_MSB = 7;
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_IN_SEL_LSB = 1;
  localparam int CTL_OUT_SEL_LSB = 5;
  localparam int P2_T2_CLK_PIN_BIT = 13;
  localparam int P2_OUT_C_BIT = 14;
  localparam int T2_ENABLE_BIT = 0;
  localparam int T2_CLK_SEL_BIT = 1;
  localparam int T2_IRQ_EN_BIT = 2;

  // pin select codes for the two-bit routing fields
  localparam logic [1:0] SEL_LINE_A = 2'h2;
  localparam logic [1:0] SEL_LINE_B = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_PORT_TWO_CONTROL = 16'h0000;
  localparam logic [2:0] RST_T2_CONTROL = 3'h1;

  // ----------------------------------------------------------------
  // timing: prescaler and timer two, when not pin clocked, run at half the system rate
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 100000000;
  localparam int HALF_RATE_HZ = 50000000;
  localparam int HALF_RATE_DIV = SYS_CLK_HZ / HALF_RATE_HZ;

endpackage : prescaled_reload_timer_pkg

// ---- prescaled_reload_timer.sv ----
// prescaled reload timer: main down counter with reload, 8-bit prescaler,
// tick toggle stage, pending flag, timer two and timer pin routing.
// assumes the core register port is synchronous to i_sys_clk and that
// pin inputs are asynchronous.
`timescale 1ns/1ps

// Summary of operation
// - reload value copied into counter on underflow
// - prescale reload held in low eight bits
// - bit 15 pending, set only by timer
// - writing one to bit 15 clears pending
// - main counter 16-bit down, always readable
// - counter write reloads and retriggers, data ignored
// - prescaler 8-bit down counter, readable
// - prescaler write reloads from reload field
// - prescaler clocked at half system rate
// - toggle stage makes 50 percent tick clock
// - prescaler at zero toggles and reloads
// - prescaler reloads on counter reload/retrigger
// - timer two counts down, reloads, interrupts
// - timer two enabled after reset, stoppable
// - timer two clock: half rate or pin
// - port-two bit 13 routes timer two clock
// - input select 10/11 routes port-one lines 6/7
// - output select 10/11 routes port-two lines 2/3
// - port-two bit 14 routes line 4 output
// - port-one input pins synchronised to tick clock
module prescaled_reload_timer (
  input wire logic i_sys_clk, // system clock, 100 MHz
  input wire logic i_resetn, // async reset, active low
  input wire logic [3:0] i_reg_idx, // register index
  input wire logic i_reg_wr, // write strobe, one cycle
  input wire logic i_reg_rd, // read strobe, one cycle
  input wire logic [15:0] i_core_data_bus, // write data
  output logic [15:0] o_rdata, // read data, valid after read
  output logic o_irq_pending_flag, // pending flag level
  output logic o_timer_two_irq, // timer two interrupt pulse
  output logic o_timer_tick_clock, // tick clock level
  input wire logic i_p1_6, // port-one line 6 pin
  input wire logic i_p1_7, // port-one line 7 pin
  input wire logic i_p2_5, // port-two line 5 pin
  output logic o_timer_input_a, // synced timer input a
  output logic o_timer_input_b, // synced timer input b
  output logic o_input_a_sel, // line 6 taken by timer
  output logic o_input_b_sel, // line 7 taken by timer
  output logic o_t2_clk_pin_sel, // line 5 taken by timer two
  input wire logic [2:0] i_p2_gpio_out, // gpio data, lines 2..4
  input wire logic [2:0] i_p2_gpio_oe_n, // gpio enables, lines 2..4
  output logic [2:0] o_p2_out, // pin data, lines 2..4
  output logic [2:0] o_p2_oe_n // pin enables, low drives
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] reload_value_reg;
  logic [7:0] prescale_reload_reg;
  logic irq_pending_flag_reg;
  logic [15:0] main_count_reg;
  logic [7:0] prescale_count_reg;
  logic half_phase_reg;
  logic tick_reg;
  logic out_wave_reg;
  logic [15:0] control_a_reg;
  logic [15:0] control_b_reg;
  logic [15:0] port_two_control_reg;
  logic [15:0] t2_load_reg;
  logic [15:0] t2_count_reg;
  logic [2:0] t2_control_reg;
  logic t2_wave_reg;
  logic t2_irq_reg;
  logic [15:0] rdata_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic ext_clk_last_reg;
  logic input_a_reg;
  logic input_b_reg;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [3:0] idx,
                               input logic [3:0] want);
    hit = (idx == want);
  endfunction : hit

  wire wr_reload = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_RELOAD_VALUE);
  wire wr_prescale_reload = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_PRESCALE_RELOAD);
  wire wr_main_count = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_MAIN_COUNT);
  wire wr_prescale_count = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_PRESCALE_COUNT);
  wire wr_control_a = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_CONTROL_A);
  wire wr_control_b = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_CONTROL_B);
  wire wr_port_two = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_PORT_TWO_CONTROL);
  wire wr_t2_load = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_T2_LOAD);
  wire wr_t2_count = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_T2_COUNT);
  wire wr_t2_control = i_reg_wr & hit(i_reg_idx,
    prescaled_reload_timer_pkg::IDX_T2_CONTROL);

  // ----------------------------------------------------------------
  // prescaler and tick generation
  // ----------------------------------------------------------------
  wire timer_enable =
    control_a_reg[prescaled_reload_timer_pkg::CTL_ENABLE_BIT];
  // prescaler steps on every other system edge
  wire half_step = half_phase_reg;
  wire prescale_zero = (prescale_count_reg == 8'h00);
  wire prescale_out = timer_enable & half_step & prescale_zero;
  wire tick_rise = prescale_out & ~tick_reg;
  wire main_zero = (main_count_reg == 16'h0000);
  wire underflow = tick_rise & main_zero;
  // any main reload also restarts the prescaler
  wire main_reload = underflow | wr_main_count;

  // prescaler count selection
  wire [7:0] prescale_next =
    (wr_prescale_count | main_reload | prescale_out) ?
      prescale_reload_reg :
    (timer_enable & half_step) ? prescale_count_reg - 8'h01 :
    prescale_count_reg;

  // main counter selection, write data never used
  wire [15:0] main_next =
    main_reload ? reload_value_reg :
    tick_rise ? main_count_reg - 16'h0001 :
    main_count_reg;

  // ----------------------------------------------------------------
  // pending flag: hardware set beats software clear
  // ----------------------------------------------------------------
  wire pend_clear = wr_prescale_reload &
    i_core_data_bus[prescaled_reload_timer_pkg::PENDING_BIT];
  wire pend_next = underflow | (irq_pending_flag_reg & ~pend_clear);

  // ----------------------------------------------------------------
  // timer two
  // ----------------------------------------------------------------
  wire t2_enable =
    t2_control_reg[prescaled_reload_timer_pkg::T2_ENABLE_BIT];
  wire t2_use_pin =
    t2_control_reg[prescaled_reload_timer_pkg::T2_CLK_SEL_BIT];
  wire t2_pin_routed =
    port_two_control_reg[prescaled_reload_timer_pkg::P2_T2_CLK_PIN_BIT];
  // pin edge only counts when line 5 is routed to timer two
  wire ext_clk_rise = sync2_reg[2] & ~ext_clk_last_reg;
  wire t2_step = t2_enable &
    (t2_use_pin ? (ext_clk_rise & t2_pin_routed) : half_step);
  wire t2_zero = (t2_count_reg == 16'h0000);
  wire t2_reload = t2_step & t2_zero;
  wire [15:0] t2_next =
    wr_t2_count ? t2_load_reg :
    t2_reload ? t2_load_reg :
    t2_step ? t2_count_reg - 16'h0001 :
    t2_count_reg;
  wire t2_irq_next = t2_reload &
    t2_control_reg[prescaled_reload_timer_pkg::T2_IRQ_EN_BIT];

  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  wire [1:0] in_sel_a = control_a_reg[2:1];
  wire [1:0] in_sel_b = control_b_reg[2:1];
  wire [1:0] out_sel_a = control_a_reg[6:5];
  wire [1:0] out_sel_b = control_b_reg[6:5];
  wire sel_in_a = (in_sel_a == prescaled_reload_timer_pkg::SEL_LINE_A) |
    (in_sel_b == prescaled_reload_timer_pkg::SEL_LINE_A);
  wire sel_in_b = (in_sel_a == prescaled_reload_timer_pkg::SEL_LINE_B) |
    (in_sel_b == prescaled_reload_timer_pkg::SEL_LINE_B);
  wire sel_out_a = (out_sel_a == prescaled_reload_timer_pkg::SEL_LINE_A) |
    (out_sel_b == prescaled_reload_timer_pkg::SEL_LINE_A);
  wire sel_out_b = (out_sel_a == prescaled_reload_timer_pkg::SEL_LINE_B) |
    (out_sel_b == prescaled_reload_timer_pkg::SEL_LINE_B);
  wire sel_out_c =
    port_two_control_reg[prescaled_reload_timer_pkg::P2_OUT_C_BIT];
  wire [2:0] timer_sel = {sel_out_c, sel_out_b, sel_out_a};
  wire [2:0] timer_wave = {t2_wave_reg, out_wave_reg, out_wave_reg};

  // ----------------------------------------------------------------
  // read mux, reserved bits read as zero
  // ----------------------------------------------------------------
  logic [15:0] read_word;
  always_comb
  begin
    case (i_reg_idx)
      prescaled_reload_timer_pkg::IDX_RELOAD_VALUE:
        read_word = reload_value_reg;
      prescaled_reload_timer_pkg::IDX_PRESCALE_RELOAD:
        read_word = {irq_pending_flag_reg, 7'h00, prescale_reload_reg};
      prescaled_reload_timer_pkg::IDX_MAIN_COUNT:
        read_word = main_count_reg;
      prescaled_reload_timer_pkg::IDX_PRESCALE_COUNT:
        read_word = {8'h00, prescale_count_reg};
      prescaled_reload_timer_pkg::IDX_CONTROL_A:
        read_word = control_a_reg;
      prescaled_reload_timer_pkg::IDX_CONTROL_B:
        read_word = control_b_reg;
      prescaled_reload_timer_pkg::IDX_PORT_TWO_CONTROL:
        read_word = port_two_control_reg;
      prescaled_reload_timer_pkg::IDX_T2_LOAD:
        read_word = t2_load_reg;
      prescaled_reload_timer_pkg::IDX_T2_COUNT:
        read_word = t2_count_reg;
      prescaled_reload_timer_pkg::IDX_T2_CONTROL:
        read_word = {13'h0, t2_control_reg};
      default:
        read_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // software-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      reload_value_reg <= prescaled_reload_timer_pkg::RST_WORD;
      prescale_reload_reg <= prescaled_reload_timer_pkg::RST_BYTE;
      control_a_reg <= prescaled_reload_timer_pkg::RST_CONTROL;
      control_b_reg <= prescaled_reload_timer_pkg::RST_CONTROL;
      port_two_control_reg <=
        prescaled_reload_timer_pkg::RST_PORT_TWO_CONTROL;
      t2_load_reg <= prescaled_reload_timer_pkg::RST_WORD;
      t2_control_reg <= prescaled_reload_timer_pkg::RST_T2_CONTROL;
    end
    else
    begin
      if (wr_reload)
        reload_value_reg <= i_core_data_bus;
      // bits 14:8 not stored, software keeps them zero
      if (wr_prescale_reload)
        prescale_reload_reg <= i_core_data_bus[7:0];
      if (wr_control_a)
        control_a_reg <= i_core_data_bus;
      if (wr_control_b)
        control_b_reg <= i_core_data_bus;
      if (wr_port_two)
        port_two_control_reg <= i_core_data_bus;
      if (wr_t2_load)
        t2_load_reg <= i_core_data_bus;
      if (wr_t2_control)
        t2_control_reg <= i_core_data_bus[2:0];
    end
  end

  // ----------------------------------------------------------------
  // counters, prescaler and tick stage
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      main_count_reg <= prescaled_reload_timer_pkg::RST_WORD;
      prescale_count_reg <= prescaled_reload_timer_pkg::RST_BYTE;
      half_phase_reg <= 1'b0;
      tick_reg <= 1'b0;
      out_wave_reg <= 1'b0;
      irq_pending_flag_reg <= 1'b0;
    end
    else
    begin
      main_count_reg <= main_next;
      prescale_count_reg <= prescale_next;
      half_phase_reg <= ~half_phase_reg;
      if (prescale_out)
        tick_reg <= ~tick_reg;
      if (underflow)
        out_wave_reg <= ~out_wave_reg;
      irq_pending_flag_reg <= pend_next;
    end
  end

  // ----------------------------------------------------------------
  // timer two
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      t2_count_reg <= prescaled_reload_timer_pkg::RST_WORD;
      t2_wave_reg <= 1'b0;
      t2_irq_reg <= 1'b0;
    end
    else
    begin
      t2_count_reg <= t2_next;
      if (t2_reload)
        t2_wave_reg <= ~t2_wave_reg;
      t2_irq_reg <= t2_irq_next;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers, then capture on the tick clock
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      ext_clk_last_reg <= 1'b0;
      input_a_reg <= 1'b0;
      input_b_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {i_p2_5, i_p1_7, i_p1_6};
      sync2_reg <= sync1_reg;
      ext_clk_last_reg <= sync2_reg[2];
      if (tick_rise)
      begin
        input_a_reg <= sync2_reg[0] & sel_in_a;
        input_b_reg <= sync2_reg[1] & sel_in_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rdata_reg <= 16'h0000;
    else if (i_reg_rd)
      rdata_reg <= read_word;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_irq_pending_flag = irq_pending_flag_reg;
  assign o_timer_two_irq = t2_irq_reg;
  assign o_timer_tick_clock = tick_reg;
  assign o_timer_input_a = input_a_reg;
  assign o_timer_input_b = input_b_reg;
  assign o_input_a_sel = sel_in_a;
  assign o_input_b_sel = sel_in_b;
  assign o_t2_clk_pin_sel = t2_pin_routed;
  // timer lines drive, others fall back to gpio
  assign o_p2_out = (timer_sel & timer_wave) |
    (~timer_sel & i_p2_gpio_out);
  assign o_p2_oe_n = ~timer_sel & i_p2_gpio_oe_n;

endmodule : prescaled_reload_timer

// ---- prescaled_reload_timer_assertions.sv ----
// checker for the prescaled reload timer register port and pins.
// assumes it is bound to prescaled_reload_timer and sees its ports only.
`timescale 1ns/1ps
module prescaled_reload_timer_assertions (
  input wire logic i_sys_clk, // system clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [3:0] i_reg_idx, // register index
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [15:0] i_core_data_bus, // write data
  input wire logic [15:0] o_rdata, // read data
  input wire logic o_irq_pending_flag, // pending flag
  input wire logic o_timer_two_irq, // timer two pulse
  input wire logic o_timer_tick_clock, // tick clock
  input wire logic o_input_a_sel, // line 6 taken
  input wire logic o_input_b_sel, // line 7 taken
  input wire logic o_t2_clk_pin_sel, // line 5 taken
  input wire logic [2:0] o_p2_oe_n // pin enables
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  // --------------------------------------------------------------
  // decoded accesses
  // --------------------------------------------------------------
  wire logic wr_ctl;
  wire logic wr_p2;
  wire logic clr_wr;
  assign wr_ctl = i_reg_wr && (i_reg_idx == 4'h4 || i_reg_idx == 4'h5);
  assign wr_p2 = i_reg_wr && i_reg_idx == 4'h6;
  assign clr_wr = i_reg_wr && i_reg_idx == 4'h1 && i_core_data_bus[15];

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  tick_high_a:
    assert property ($rose(o_timer_tick_clock) |=> o_timer_tick_clock)
    else $error("tick clock high for a single cycle");
  tick_low_a:
    assert property ($fell(o_timer_tick_clock) |=> !o_timer_tick_clock)
    else $error("tick clock low for a single cycle");
  pend_clear_a:
    assert property ($fell(o_irq_pending_flag) |-> $past(clr_wr))
    else $error("pending flag fell without a clearing write");
  spare_bits_a:
    assert property (i_reg_rd && i_reg_idx == 4'h1 |=> o_rdata[14:8] == 7'h00)
    else $error("prescale reload bits 14:8 read nonzero");
  pre_width_a:
    assert property (i_reg_rd && i_reg_idx == 4'h3 |=> o_rdata[15:8] == 8'h00)
    else $error("prescale count wider than eight bits");
  t2_pulse_a:
    assert property (o_timer_two_irq |=> !o_timer_two_irq)
    else $error("timer two interrupt longer than one cycle");
  in_route_a:
    assert property (wr_ctl && i_core_data_bus[2:1] == 2'h2 |=> o_input_a_sel)
    else $error("input select code did not route line 6");
  out_route_a:
    assert property (wr_ctl && i_core_data_bus[6:5] == 2'h3 |=> !o_p2_oe_n[1])
    else $error("output select code did not drive line 3");
  t2_pin_a:
    assert property (wr_p2 |=> o_t2_clk_pin_sel == $past(i_core_data_bus[13]))
    else $error("timer two clock pin select does not follow bit 13");
  line4_out_a:
    assert property (wr_p2 && i_core_data_bus[14] |=> !o_p2_oe_n[2])
    else $error("line 4 not driven by timer");

  // main scenarios reached
  cover property ($rose(o_irq_pending_flag));
  cover property (o_timer_two_irq);
  cover property ($rose(o_timer_tick_clock));
endmodule : prescaled_reload_timer_assertions

bind prescaled_reload_timer prescaled_reload_timer_assertions chk (
  .i_sys_clk, .i_resetn, .i_reg_idx, .i_reg_wr, .i_reg_rd,
  .i_core_data_bus, .o_rdata, .o_irq_pending_flag, .o_timer_two_irq,
  .o_timer_tick_clock, .o_input_a_sel, .o_input_b_sel, .o_t2_clk_pin_sel,
  .o_p2_oe_n
);

// ---- core_bus_model.sv ----
// model of the core issuing register reads and writes.
// assumes the design samples strobes on the rising edge.
`timescale 1ns/1ps
module core_bus_model (
  input wire logic i_sys_clk, // system clock
  output logic [3:0] o_idx, // register index
  output logic o_wr, // write strobe
  output logic o_rd, // read strobe
  output logic [15:0] o_data // write data
);
  initial
  begin
    o_idx = 4'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_data = 16'h0000;
  end

  // one write, held across one rising edge
  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    @(negedge i_sys_clk);
    o_idx = idx;
    o_data = (idx == prescaled_reload_timer_pkg::IDX_PRESCALE_RELOAD) ?
      (d & 16'h80FF) : d;
    o_wr = 1'b1;
    @(negedge i_sys_clk);
    o_wr = 1'b0;
    o_data = ~o_data; // released bus shows no stale word
  endtask : wr

  // one read strobe; the data is judged by the bench
  task automatic rd(input logic [3:0] idx);
    @(negedge i_sys_clk);
    o_idx = idx;
    o_rd = 1'b1;
    @(negedge i_sys_clk);
    o_rd = 1'b0;
  endtask : rd
endmodule : core_bus_model

// ---- prescaled_reload_timer_tb.sv ----
// self-checking bench for the prescaled reload timer.
// assumes core_bus_model drives the register port.
`timescale 1ns/1ps
module prescaled_reload_timer_tb;
  logic clk, resetn, p16, p17, p25, pend, irq, tick, ina, inb;
  logic asel, bsel, t2sel, rd_s, wr_s;
  logic [2:0] gout, goe, pout, oen;
  logic [3:0] idx;
  logic [15:0] data, rdata, r, per, cnt, irq_cnt, irq_base;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  core_bus_model core (.i_sys_clk(clk), .o_idx(idx), .o_wr(wr_s),
    .o_rd(rd_s), .o_data(data));
  prescaled_reload_timer dut (.i_sys_clk(clk), .i_resetn(resetn),
    .i_reg_idx(idx), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
    .i_core_data_bus(data), .o_rdata(rdata), .o_irq_pending_flag(pend),
    .o_timer_two_irq(irq), .o_timer_tick_clock(tick), .i_p1_6(p16),
    .i_p1_7(p17), .i_p2_5(p25), .o_timer_input_a(ina),
    .o_timer_input_b(inb), .o_input_a_sel(asel), .o_input_b_sel(bsel),
    .o_t2_clk_pin_sel(t2sel), .i_p2_gpio_out(gout), .i_p2_gpio_oe_n(goe),
    .o_p2_out(pout), .o_p2_oe_n(oen));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic close_out();
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // read with the expected word noted for the monitor
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    exp_q.push_back(e);
    core.rd(i);
  endtask : rd

  // counts tick rises (s=0, stops on pending) or t2 pulses (s=1)
  task automatic meas(input logic s, input int lim);
    logic p = 1'b0;
    int t = 0;
    int last = 0;
    cnt = 16'h0000;
    per = 16'h0000;
    while (t < lim && !(s == 1'b0 && pend === 1'b1))
    begin
      @(posedge clk);
      #1;
      t++;
      if ((s ? irq : (tick & ~p)) === 1'b1)
      begin
        per = 16'(t - last);
        last = t;
        cnt++;
      end
      p = tick;
    end
  endtask : meas

  // read data monitor, timeout and timer two pulse counter
  always @(posedge clk)
  begin
    cyc++;
    if (!resetn)
      irq_cnt <= 16'h0000;
    else if (irq === 1'b1)
      irq_cnt <= irq_cnt + 16'h0001;
    if (rd_s === 1'b1)
    begin
      #1;
      chk("rdata", exp_q.pop_front(), rdata);
    end
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    {p16, p17, p25} = 3'h0;
    gout = 3'h0;
    goe = 3'h7;
    r = 16'h58B5;
    repeat (20) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 16; i++)
      rd(i[3:0], (i == 9) ? 16'h0001 : 16'h0000);
    r = lfsr(r);
    {p16, p17} = r[1:0];
    core.wr(4'h0, r);
    rd(4'h0, r);
    core.wr(4'h1, 16'hFFAB);
    rd(4'h1, 16'h00AB);
    core.wr(4'h3, 16'h1234);
    rd(4'h3, 16'h00AB);
    core.wr(4'h1, 16'h0011);
    core.wr(4'h2, 16'h5A5A);
    rd(4'h2, r);
    rd(4'h3, 16'h0011);
    core.wr(4'h0, 16'h0003);
    core.wr(4'h1, 16'h0002);
    core.wr(4'h2, 16'h0000);
    core.wr(4'h4, 16'h0005);
    meas(1'b0, 200);
    chk("tick_period", 16'h000C, per);
    chk("ticks_to_underflow", 16'h0004, cnt);
    chk("in_capture", {14'h0, 1'b0, p16}, {14'h0, inb, ina});
    rd(4'h1, 16'h8002);
    core.wr(4'h1, 16'h0002);
    rd(4'h1, 16'h8002);
    core.wr(4'h4, 16'h0000);
    core.wr(4'h1, 16'h8002);
    rd(4'h1, 16'h0002);
    for (int c = 2; c < 4; c++)
      for (int k = 4; k < 6; k++)
      begin
        core.wr(k[3:0], {9'h000, c[1:0], 2'h0, c[1:0], 1'b0});
        chk("in_sel", {14'h0, c[0], ~c[0]}, {14'h0, bsel, asel});
        chk("out_oe", {14'h0, ~c[0], c[0]}, {14'h0, oen[1:0]});
        chk("out_wave", {14'h0, c[0], ~c[0]}, {14'h0, pout[1:0]});
        core.wr(k[3:0], 16'h0000);
      end
    r = lfsr(r);
    gout = r[2:0];
    core.wr(4'h6, 16'h6000);
    chk("t2_pin_sel", 16'h0001, {15'h0, t2sel});
    chk("line4_oe", 16'h0000, {15'h0, oen[2]});
    core.wr(4'h6, 16'h0000);
    chk("gpio_pass", {13'h0, gout}, {13'h0, pout});
    core.wr(4'h7, 16'h0005);
    core.wr(4'h8, 16'h0000);
    core.wr(4'h9, 16'h0005);
    meas(1'b1, 40);
    chk("t2_period", 16'h000C, per);
    core.wr(4'h9, 16'h0004);
    meas(1'b1, 40);
    chk("t2_stopped", 16'h0000, cnt);
    core.wr(4'h6, 16'h2000);
    core.wr(4'h9, 16'h0007);
    core.wr(4'h8, 16'h0000);
    irq_base = irq_cnt;
    repeat (24)
    begin
      repeat (4) @(negedge clk);
      p25 = ~p25;
    end
    repeat (10) @(negedge clk);
    chk("t2_pin_irqs", 16'h0002, irq_cnt - irq_base);
    close_out();
  end
endmodule : prescaled_reload_timer_tb
